// >>> hw/dsr_pkg.sv
/*
 * Constants, register map and state type of the debug serial receiver.
 * Assumes a 32-bit APB with byte addresses; registers are aligned words.
 */
package dsr_pkg;

    // ========================================
    // Register offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_MODE = 8'h04;
    localparam logic [7:0] OFF_STAT = 8'h08;
    localparam logic [7:0] OFF_EVT  = 8'h0C;
    localparam logic [7:0] OFF_MASK = 8'h10;
    localparam logic [7:0] OFF_HOLD = 8'h14;
    localparam logic [7:0] OFF_DIV  = 8'h18;

    // ========================================
    // Field positions
    localparam int CTL_RESET_BIT    = 2;
    localparam int CTL_ENABLE_BIT   = 4;
    localparam int CTL_DISABLE_BIT  = 5;
    localparam int MODE_PAR_EN_BIT  = 0;
    localparam int MODE_PAR_ODD_BIT = 1;
    localparam int STAT_READY_BIT   = 0;
    localparam int STAT_ENABLED_BIT = 1;
    localparam int STAT_BUSY_BIT    = 2;
    localparam int EVT_CHAR_BIT     = 0;
    localparam int EVT_OVERRUN_BIT  = 1;
    localparam int EVT_FRAME_BIT    = 2;
    localparam int EVT_PARITY_BIT   = 3;
    localparam int EVT_W            = 4;

    // ========================================
    // Reset values
    localparam logic [1:0]  MODE_RESET = 2'h0;
    localparam logic [3:0]  MASK_RESET = 4'h0;
    localparam logic [15:0] DIV_RESET  = 16'h0000;

    // ========================================
    // Timing in sampling ticks
    localparam int                CNT_W             = 5;
    localparam logic [CNT_W-1:0]  BIT_TICKS         = 5'h10;
    localparam logic [CNT_W-1:0]  HALF_BIT_TICKS    = 5'h08;
    localparam logic [CNT_W-1:0]  START_LOW_TICKS   = 5'h08;
    localparam logic [CNT_W-1:0]  FIRST_SAMPLE_TICKS = BIT_TICKS + HALF_BIT_TICKS;
    localparam logic [2:0]        LAST_DATA_BIT     = 3'h7;

    // ========================================
    // Receiver states
    typedef enum logic [2:0] {
        RX_OFF    = 3'b000,
        RX_HUNT   = 3'b001,
        RX_START  = 3'b010,
        RX_DATA   = 3'b011,
        RX_PARITY = 3'b100,
        RX_STOP   = 3'b101
    } dsr_state_t;

endpackage : dsr_pkg

// >>> hw/dsr_baud_div.sv
/*
 * Programmable divider making the 16x sampling tick from pclk.
 * Assumes the divisor is static while the receiver runs; zero stops ticks.
 */
`timescale 1ns/10ps
`default_nettype none

module dsr_baud_div #(
    parameter int DIV_W = 16
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Divisor and tick
    input  wire logic [DIV_W-1:0] divisor,
    output logic                  tick
);

    logic [DIV_W-1:0] cnt_q;
    logic [DIV_W-1:0] cnt_d;
    logic             tick_q;
    logic             tick_d;

    // ========================================
    // Divider
    always_comb begin
        tick_d = 1'b0;
        cnt_d  = cnt_q + {{(DIV_W-1){1'b0}}, 1'b1};
        if (divisor == '0) begin
            cnt_d = '0;
        end else if (cnt_q >= divisor - {{(DIV_W-1){1'b0}}, 1'b1}) begin
            cnt_d  = '0;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;

endmodule : dsr_baud_div

`default_nettype wire

// >>> hw/dsr_rx.sv
/*
 * Debug serial receiver: APB registers, 16x oversampling start detection,
 * mid-bit sampling, holding register with ready flag, masked interrupt.
 * Assumes serial_receive_input is already synchronous to pclk.
 */
`timescale 1ns/10ps
`default_nettype none

module dsr_rx #(
    parameter int DIV_W = 16
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Serial line
    input  wire logic        serial_receive_input,
    // Interrupt
    output logic             irq
);

    // ========================================
    // Declarations
    logic                       tick;
    dsr_pkg::dsr_state_t        state_q, state_d;
    logic [dsr_pkg::CNT_W-1:0]  tcnt_q, tcnt_d;
    logic [2:0]                 bitidx_q, bitidx_d;
    logic [7:0]                 shift_q, shift_d;
    logic                       perr_q, perr_d;
    logic                       stop_pend_q, stop_pend_d;
    logic                       char_done;
    logic                       frame_bad;
    logic [1:0]                 mode_q, mode_d;
    logic [3:0]                 mask_q, mask_d;
    logic [3:0]                 evt_q, evt_d;
    logic [DIV_W-1:0]           div_q, div_d;
    logic [7:0]                 hold_q, hold_d;
    logic                       ready_q, ready_d;
    logic [31:0]                prdata_q, prdata_d;
    logic                       pready_q, pready_d;
    logic                       pslverr_q, pslverr_d;
    logic                       irq_q, irq_d;
    logic                       acc;
    logic                       wr;
    logic                       rd;
    logic                       cmd_reset;
    logic                       cmd_enable;
    logic                       cmd_disable;
    logic [dsr_pkg::CNT_W-1:0]  tnext;
    logic                       parity_en;

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        hit = (addr == off);
    endfunction : hit

    function automatic logic parity_ok(input logic [7:0] d, input logic p, input logic odd);
        parity_ok = ((^d) ^ p) == odd;
    endfunction : parity_ok

    // ========================================
    // Sampling tick
    dsr_baud_div #(
        .DIV_W   (DIV_W)
    ) u_div (
        .pclk    (pclk),
        .presetn (presetn),
        .divisor (div_q),
        .tick    (tick)
    );

    // ========================================
    // Bus decode
    // Wait state of one cycle so every answer leaves a flip-flop
    assign acc         = psel && penable && pready_q;
    assign wr          = acc && pwrite;
    assign rd          = acc && !pwrite;
    assign cmd_reset   = wr && hit(paddr, dsr_pkg::OFF_CTRL) && pwdata[dsr_pkg::CTL_RESET_BIT];
    assign cmd_enable  = wr && hit(paddr, dsr_pkg::OFF_CTRL) && pwdata[dsr_pkg::CTL_ENABLE_BIT];
    assign cmd_disable = wr && hit(paddr, dsr_pkg::OFF_CTRL) && pwdata[dsr_pkg::CTL_DISABLE_BIT];
    assign tnext       = tcnt_q + 5'h01;
    assign parity_en   = mode_q[dsr_pkg::MODE_PAR_EN_BIT];

    // ========================================
    // Receiver next state
    always_comb begin
        state_d     = state_q;
        tcnt_d      = tcnt_q;
        bitidx_d    = bitidx_q;
        shift_d     = shift_q;
        perr_d      = perr_q;
        stop_pend_d = stop_pend_q;
        char_done   = 1'b0;
        frame_bad   = 1'b0;
        if (cmd_disable && state_q != dsr_pkg::RX_OFF) begin
            stop_pend_d = 1'b1;
        end
        if (tick) begin
            unique case (state_q)
                dsr_pkg::RX_OFF: begin
                end
                dsr_pkg::RX_HUNT: begin
                    if (!serial_receive_input) begin
                        state_d = dsr_pkg::RX_START;
                        tcnt_d  = '0;
                    end
                end
                dsr_pkg::RX_START: begin
                    tcnt_d = tnext;
                    if (tnext < dsr_pkg::START_LOW_TICKS && serial_receive_input) begin
                        state_d = dsr_pkg::RX_HUNT;
                    end else if (tnext == dsr_pkg::FIRST_SAMPLE_TICKS) begin
                        shift_d  = {serial_receive_input, shift_q[7:1]};
                        state_d  = dsr_pkg::RX_DATA;
                        tcnt_d   = '0;
                        bitidx_d = 3'h1;
                        perr_d   = 1'b0;
                    end
                end
                dsr_pkg::RX_DATA: begin
                    tcnt_d = tnext;
                    if (tnext == dsr_pkg::BIT_TICKS) begin
                        shift_d  = {serial_receive_input, shift_q[7:1]};
                        tcnt_d   = '0;
                        bitidx_d = bitidx_q + 3'h1;
                        if (bitidx_q == dsr_pkg::LAST_DATA_BIT) begin
                            state_d = parity_en ? dsr_pkg::RX_PARITY : dsr_pkg::RX_STOP;
                        end
                    end
                end
                dsr_pkg::RX_PARITY: begin
                    tcnt_d = tnext;
                    if (tnext == dsr_pkg::BIT_TICKS) begin
                        perr_d  = !parity_ok(shift_q, serial_receive_input,
                                             mode_q[dsr_pkg::MODE_PAR_ODD_BIT]);
                        tcnt_d  = '0;
                        state_d = dsr_pkg::RX_STOP;
                    end
                end
                dsr_pkg::RX_STOP: begin
                    tcnt_d = tnext;
                    if (tnext == dsr_pkg::BIT_TICKS) begin
                        char_done = 1'b1;
                        frame_bad = !serial_receive_input;
                        tcnt_d    = '0;
                        // Once the start is confirmed, a pending disable takes effect only here
                        state_d   = (stop_pend_d) ? dsr_pkg::RX_OFF : dsr_pkg::RX_HUNT;
                    end
                end
                default: begin
                    state_d = dsr_pkg::RX_OFF;
                end
            endcase
        end
        // Before the start is confirmed the receiver still counts as idle
        if (stop_pend_d && (state_d == dsr_pkg::RX_HUNT ||
            (state_d == dsr_pkg::RX_START && tcnt_d < dsr_pkg::START_LOW_TICKS - 5'h01))) begin
            state_d = dsr_pkg::RX_OFF;
        end
        if (state_d == dsr_pkg::RX_OFF) begin
            stop_pend_d = 1'b0;
        end
        if (cmd_enable && !cmd_disable && state_q == dsr_pkg::RX_OFF) begin
            state_d = dsr_pkg::RX_HUNT;
        end
        if (cmd_reset) begin
            state_d     = dsr_pkg::RX_OFF;
            tcnt_d      = '0;
            bitidx_d    = '0;
            shift_d     = '0;
            perr_d      = 1'b0;
            stop_pend_d = 1'b0;
            char_done   = 1'b0;
            frame_bad   = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q     <= dsr_pkg::RX_OFF;
            tcnt_q      <= '0;
            bitidx_q    <= '0;
            shift_q     <= '0;
            perr_q      <= 1'b0;
            stop_pend_q <= 1'b0;
        end else begin
            state_q     <= state_d;
            tcnt_q      <= tcnt_d;
            bitidx_q    <= bitidx_d;
            shift_q     <= shift_d;
            perr_q      <= perr_d;
            stop_pend_q <= stop_pend_d;
        end
    end

    // ========================================
    // Registers and bus answer
    always_comb begin
        mode_d    = mode_q;
        mask_d    = mask_q;
        div_d     = div_q;
        hold_d    = hold_q;
        ready_d   = ready_q;
        evt_d     = evt_q;
        prdata_d  = prdata_q;
        pslverr_d = 1'b0;
        pready_d  = psel && penable && !pready_q;
        if (wr) begin
            if (hit(paddr, dsr_pkg::OFF_MODE)) begin
                mode_d = pwdata[1:0];
            end
            if (hit(paddr, dsr_pkg::OFF_MASK)) begin
                mask_d = pwdata[dsr_pkg::EVT_W-1:0];
            end
            if (hit(paddr, dsr_pkg::OFF_DIV)) begin
                div_d = pwdata[DIV_W-1:0];
            end
            if (hit(paddr, dsr_pkg::OFF_EVT)) begin
                evt_d = evt_q & ~pwdata[dsr_pkg::EVT_W-1:0];
            end
        end
        if (rd && hit(paddr, dsr_pkg::OFF_HOLD)) begin
            ready_d = 1'b0;
        end
        // Hardware set wins over any clear in the same cycle
        if (char_done) begin
            hold_d                          = shift_q;
            ready_d                         = 1'b1;
            evt_d[dsr_pkg::EVT_CHAR_BIT]    = 1'b1;
            evt_d[dsr_pkg::EVT_OVERRUN_BIT] = evt_d[dsr_pkg::EVT_OVERRUN_BIT] | ready_q;
            evt_d[dsr_pkg::EVT_FRAME_BIT]   = evt_d[dsr_pkg::EVT_FRAME_BIT] | frame_bad;
            evt_d[dsr_pkg::EVT_PARITY_BIT]  = evt_d[dsr_pkg::EVT_PARITY_BIT] | (parity_en & perr_q);
        end
        if (pready_d) begin
            prdata_d = 32'h0000_0000;
            unique case (paddr)
                dsr_pkg::OFF_CTRL: begin
                end
                dsr_pkg::OFF_MODE: begin
                    prdata_d[1:0] = mode_q;
                end
                dsr_pkg::OFF_STAT: begin
                    prdata_d[dsr_pkg::STAT_READY_BIT]   = ready_q;
                    prdata_d[dsr_pkg::STAT_ENABLED_BIT] = (state_q != dsr_pkg::RX_OFF);
                    prdata_d[dsr_pkg::STAT_BUSY_BIT]    = (state_q != dsr_pkg::RX_OFF) &&
                                                          (state_q != dsr_pkg::RX_HUNT);
                end
                dsr_pkg::OFF_EVT: begin
                    prdata_d[dsr_pkg::EVT_W-1:0] = evt_q;
                end
                dsr_pkg::OFF_MASK: begin
                    prdata_d[dsr_pkg::EVT_W-1:0] = mask_q;
                end
                dsr_pkg::OFF_HOLD: begin
                    prdata_d[7:0] = hold_q;
                end
                dsr_pkg::OFF_DIV: begin
                    prdata_d[DIV_W-1:0] = div_q;
                end
                default: begin
                    pslverr_d = 1'b1;
                end
            endcase
        end
        irq_d = |(evt_d & mask_d);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q    <= dsr_pkg::MODE_RESET;
            mask_q    <= dsr_pkg::MASK_RESET;
            div_q     <= dsr_pkg::DIV_RESET;
            hold_q    <= 8'h00;
            ready_q   <= 1'b0;
            evt_q     <= 4'h0;
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            irq_q     <= 1'b0;
        end else begin
            mode_q    <= mode_d;
            mask_q    <= mask_d;
            div_q     <= div_d;
            hold_q    <= hold_d;
            ready_q   <= ready_d;
            evt_q     <= evt_d;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
            irq_q     <= irq_d;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;
    assign irq     = irq_q;

endmodule : dsr_rx

`default_nettype wire

// >>> bench/dsr_rx_sva.sv
/* Port checker of dsr_rx.
   Assumes it is bound to every dsr_rx instance. */
`timescale 1ns/10ps
`default_nettype none

module dsr_rx_sva (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Line and interrupt
    input wire logic        serial_receive_input,
    input wire logic        irq
);
    // ========================================
    // Transfer steps
    default clocking cb @(posedge pclk); endclocking
    wire logic done = psel && penable && pready;
    wire logic unm  = paddr > 8'h18 || paddr[1:0] != 2'h0;
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    sequence s_rd(a);
        done && !pwrite && paddr == a;
    endsequence

    // ========================================
    // Assertions
    a_one_wait: assert property (disable iff (!presetn)
        s_setup ##1 s_access |-> !pready ##1 pready) else $error("pready not after one wait");
    a_ready_pulse: assert property (disable iff (!presetn)
        pready |=> !pready) else $error("pready longer than one cycle");
    a_unmapped_err: assert property (disable iff (!presetn)
        done && unm && !pwrite |-> pslverr && prdata == 32'h0) else $error("unmapped read");
    a_mapped_ok: assert property (disable iff (!presetn)
        done && !unm |-> !pslverr) else $error("error on mapped address");
    a_ctrl_zero: assert property (disable iff (!presetn)
        s_rd(dsr_pkg::OFF_CTRL) |-> prdata == 32'h0) else $error("control read not zero");
    a_hold_clears: assert property (disable iff (!presetn)
        s_rd(dsr_pkg::OFF_HOLD) ##[1:6] s_rd(dsr_pkg::OFF_STAT) |-> !prdata[0])
        else $error("ready still set after holding read");
    a_reset_quiet: assert property (
        !presetn |-> !pready && !irq && prdata == 32'h0) else $error("outputs active in reset");
    a_irq_masked: assert property (disable iff (!presetn)
        s_rd(dsr_pkg::OFF_MASK) ##0 prdata[3:0] == 4'h0 |-> !irq ##1 !irq)
        else $error("irq with all events masked");
endmodule : dsr_rx_sva

bind dsr_rx dsr_rx_sva u_dsr_rx_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .serial_receive_input, .irq);

`default_nettype wire

// >>> bench/dsr_tx_model.sv
/* Remote serial transmitter driving the receive line.
   Assumes one sampling tick every TCLK pclk cycles. */
`timescale 1ns/10ps
`default_nettype none

module dsr_tx_model #(
    parameter int TCLK = 2
) (
    // Clock
    input  wire logic       pclk,
    // Frame request
    input  wire logic       go,
    input  wire logic [7:0] tx_byte,
    input  wire logic [7:0] low_ticks,
    input  wire logic       par_en,
    input  wire logic       par_odd,
    // Line
    output logic            line,
    output logic            busy
);
    localparam int BIT = 16 * TCLK;

    task automatic hold(input logic v, input int n);
        line <= v;
        repeat (n) @(posedge pclk);
    endtask : hold

    // ========================================
    // Frames; line idles high
    initial begin
        line = 1'b1;
        busy = 1'b0;
        forever begin
            @(posedge pclk);
            if (go === 1'b1) begin
                busy <= 1'b1;
                if (low_ticks != 8'h00) begin
                    // Space only, then a frame time of idle
                    hold(1'b0, low_ticks * TCLK);
                    hold(1'b1, 10 * BIT);
                end else begin
                    hold(1'b0, BIT);
                    for (int i = 0; i < 8; i++) hold(tx_byte[i], BIT);
                    if (par_en) hold(^tx_byte ^ par_odd, BIT);
                    hold(1'b1, BIT);
                end
                busy <= 1'b0;
            end
        end
    end
endmodule : dsr_tx_model

`default_nettype wire

// >>> bench/dsr_rx_bench.sv
/* Self-checking bench of dsr_rx with a transmitter model.
   Assumes divisor 2, so one bit is 32 pclk cycles. */
`timescale 1ns/10ps
`default_nettype none

module dsr_rx_bench;
    localparam int TCLK = 2;
    logic             pclk      = 1'b0;
    logic             presetn;
    logic             psel      = 1'b0;
    logic             penable   = 1'b0;
    logic             pwrite    = 1'b0;
    logic [7:0]       paddr     = 8'h00;
    logic [31:0]      pwdata    = 32'h0;
    logic             go        = 1'b0;
    logic [7:0]       tx_byte   = 8'h00;
    logic [7:0]       low_ticks = 8'h00;
    logic             par_en    = 1'b0;
    logic             par_odd   = 1'b0;
    logic [15:0]      lfsr_q    = 16'h3041;
    logic [32:0]      exp_q[$];
    logic [32:0]      msk_q[$];
    logic [32:0]      mon_e;
    logic [32:0]      mon_m;
    wire logic [31:0] prdata;
    wire logic        pready;
    wire logic        pslverr;
    wire logic        rxd;
    wire logic        irq;
    wire logic        tx_busy;
    int               n_fail          = 0;
    int               samples_checked = 0;

    always #2.5 pclk = ~pclk;

    dsr_rx u_dsr_rx (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .serial_receive_input(rxd), .irq(irq));
    dsr_tx_model #(.TCLK(TCLK)) u_dsr_tx_model (.pclk(pclk), .go(go), .tx_byte(tx_byte),
        .low_ticks(low_ticks), .par_en(par_en), .par_odd(par_odd), .line(rxd), .busy(tx_busy));

    // ========================================
    // Checking and closing
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic summarize;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize

    // Takes the oldest note at each completed transfer
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1) begin
            mon_e = exp_q.pop_front();
            mon_m = msk_q.pop_front();
            check({pslverr, prdata} & mon_m, mon_e & mon_m);
        end
    end

    // ========================================
    // Drivers
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
        int i;
        exp_q.push_back({a > 8'h18 || a[1:0] != 2'h0, d});
        msk_q.push_back({1'b1, w ? 32'h0 : m});
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            n_fail++;
            summarize();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic start_tx(input logic [7:0] b, input logic [7:0] lt);
        tx_byte   <= b;
        low_ticks <= lt;
        go        <= 1'b1;
        @(posedge pclk);
        go        <= 1'b0;
    endtask : start_tx

    task automatic wait_tx;
        int i;
        for (i = 0; i < 2000; i++) begin
            @(posedge pclk);
            if (tx_busy === 1'b0) break;
        end
        if (i == 2000) begin
            n_fail++;
            summarize();
        end
    endtask : wait_tx

    // ========================================
    // Scenarios
    initial begin
        // Falling edge at time zero fires the asynchronous reset
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, dsr_pkg::OFF_STAT, 32'h0, 32'h7);
        apb(1'b0, dsr_pkg::OFF_MODE, 32'h0, 32'hFFFFFFFF);
        apb(1'b0, dsr_pkg::OFF_MASK, 32'h0, 32'hFFFFFFFF);
        apb(1'b0, dsr_pkg::OFF_DIV, 32'h0, 32'hFFFFFFFF);
        apb(1'b0, dsr_pkg::OFF_CTRL, 32'h0, 32'hFFFFFFFF);
        apb(1'b0, 8'h1C, 32'h0, 32'hFFFFFFFF);
        apb(1'b1, 8'h1C, 32'h0, 32'h0);
        apb(1'b1, dsr_pkg::OFF_DIV, 32'h2, 32'h0);
        apb(1'b0, dsr_pkg::OFF_DIV, 32'h2, 32'hFFFF);
        start_tx(8'hA5, 8'h00);
        wait_tx();
        apb(1'b0, dsr_pkg::OFF_STAT, 32'h0, 32'h7);
        apb(1'b1, dsr_pkg::OFF_MASK, 32'h1, 32'h0);
        apb(1'b1, dsr_pkg::OFF_CTRL, 32'h10, 32'h0);
        // Every parity mode, random characters
        for (int k = 0; k < 4; k++) begin
            lfsr_q = lfsr_next(lfsr_q);
            par_en  <= k[0];
            par_odd <= k[1];
            apb(1'b1, dsr_pkg::OFF_MODE, k, 32'h0);
            start_tx(lfsr_q[7:0], 8'h00);
            wait_tx();
            apb(1'b0, dsr_pkg::OFF_STAT, 32'h3, 32'h3);
            apb(1'b0, dsr_pkg::OFF_EVT, 32'h1, 32'hF);
            check({32'h0, irq}, 33'h1);
            apb(1'b0, dsr_pkg::OFF_HOLD, {24'h0, lfsr_q[7:0]}, 32'hFF);
            apb(1'b0, dsr_pkg::OFF_STAT, 32'h2, 32'h3);
            apb(1'b1, dsr_pkg::OFF_EVT, 32'h1, 32'h0);
            repeat (2) @(posedge pclk);
            check({32'h0, irq}, 33'h0);
        end
        // Space of seven ticks is a glitch, eight is the shortest start
        start_tx(8'h00, 8'h07);
        wait_tx();
        apb(1'b0, dsr_pkg::OFF_STAT, 32'h2, 32'h7);
        start_tx(8'h00, 8'h08);
        wait_tx();
        apb(1'b0, dsr_pkg::OFF_HOLD, 32'hFF, 32'hFF);
        // Error events: space over the stop bit, wrong parity, unread character
        apb(1'b1, dsr_pkg::OFF_EVT, 32'hF, 32'h0);
        start_tx(8'h00, 8'hB0);
        wait_tx();
        apb(1'b0, dsr_pkg::OFF_EVT, 32'hD, 32'hF);
        apb(1'b1, dsr_pkg::OFF_EVT, 32'hF, 32'h0);
        par_odd <= 1'b0;
        lfsr_q = lfsr_next(lfsr_q);
        start_tx(lfsr_q[7:0], 8'h00);
        wait_tx();
        apb(1'b0, dsr_pkg::OFF_EVT, 32'hB, 32'hF);
        apb(1'b0, dsr_pkg::OFF_HOLD, {24'h0, lfsr_q[7:0]}, 32'hFF);
        par_odd <= 1'b1;
        // Disable in mid-character finishes it
        lfsr_q = lfsr_next(lfsr_q);
        start_tx(lfsr_q[7:0], 8'h00);
        repeat (100) @(posedge pclk);
        apb(1'b1, dsr_pkg::OFF_CTRL, 32'h20, 32'h0);
        wait_tx();
        apb(1'b0, dsr_pkg::OFF_STAT, 32'h1, 32'h3);
        apb(1'b0, dsr_pkg::OFF_HOLD, {24'h0, lfsr_q[7:0]}, 32'hFF);
        // Disable while idle stops at once
        apb(1'b1, dsr_pkg::OFF_CTRL, 32'h10, 32'h0);
        apb(1'b1, dsr_pkg::OFF_CTRL, 32'h20, 32'h0);
        start_tx(8'h5A, 8'h00);
        wait_tx();
        apb(1'b0, dsr_pkg::OFF_STAT, 32'h0, 32'h7);
        // Reset bit in mid-character drops it
        apb(1'b1, dsr_pkg::OFF_CTRL, 32'h10, 32'h0);
        start_tx(8'h81, 8'h00);
        repeat (100) @(posedge pclk);
        apb(1'b1, dsr_pkg::OFF_CTRL, 32'h4, 32'h0);
        wait_tx();
        apb(1'b0, dsr_pkg::OFF_STAT, 32'h0, 32'h7);
        summarize();
    end
endmodule : dsr_rx_bench

`default_nettype wire
